// >>> logic/charger_status_fault_regs.sv
/*
 * Status, ship-mode, fault-flag/mask and temperature-sense control
 * register bank of a battery charge manager, reached over a serial
 * two-wire slave port.
 * Assumes condition inputs come from analog comparators outside the
 * clock domain; the bus master does not need clock stretching.
 */
// Notes on behaviour
// - charge state bits 7:6 show live condition
// - status bit 5 write-only ship request, reset 0
// - reset flag set on event, read clears
// - timer flag held; cleared by disable toggle
// - status bit 2 mirrors input dpm activity
// - overvoltage flag held while condition persists
// - undervoltage flag once per event, read clears
// - battery undervoltage flag held while present
// - battery overcurrent flag cleared by read
// - fault bits 3:0 masks, reset zero
// - status resets bit5 clear, bit0 set
// - fault flags read-only, masks read-write
// - ts bit7, bits3:0 read-write, reset 1/1000
// - unmapped register reads all ones
// - slave address 6A, seven-bit addressing
`timescale 1ns/1ns
`default_nettype none

module charger_status_fault_regs (
	// clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_nrst,
	// serial bus pins
	input  wire logic       i_scl,
	input  wire logic       i_sda_in,
	output logic            o_sda_out,
	output logic            o_sda_oe_n,
	// charger conditions
	input  wire logic [1:0] i_charge_state,
	input  wire logic       i_reset_condition,
	input  wire logic       i_timer_fault,
	input  wire logic       i_chip_disable_input,
	input  wire logic       i_input_dpm_active,
	input  wire logic       i_input_overvoltage,
	input  wire logic       i_input_undervoltage,
	input  wire logic       i_battery_undervoltage,
	input  wire logic       i_battery_overcurrent,
	input  wire logic       i_sys_switch_en,
	input  wire logic [1:0] i_ts_fault_mode,
	// control outputs
	output logic            o_ship_mode_request,
	output logic      [3:0] o_fault_masks,
	output logic            o_ts_enable,
	output logic      [3:0] o_ts_event_ctrl
);
	import charger_regs_pkg::*;

	logic [NPINS-1:0] pins;
	logic [NPINS-1:0] s1_q;
	logic [NPINS-1:0] s2_q;
	logic [NPINS-1:0] s3_q;
	logic [NPINS-1:0] pin_q;
	logic [NPINS-1:0] prev_q;
	logic [7:0]       rd_data;
	logic [7:0]       ptr;
	logic             wr;
	logic [7:0]       wr_addr;
	logic [7:0]       wr_data;
	logic             rd_done;
	logic [7:0]       done_addr;
	logic             port_oe_n;
	logic             rstf_q;
	logic             tmr_q;
	logic             ov_q;
	logic             uv_q;
	logic             buv_q;
	logic             ocp_q;
	logic             clr_status;
	logic             clr_fault;
	logic             rst_rise;
	logic             uv_rise;
	logic             ocp_rise;
	logic             cd_edge;

	// -------------------------------------------------------------
	// input synchronisers
	// -------------------------------------------------------------
	assign pins = {i_ts_fault_mode, i_charge_state, i_sys_switch_en,
		i_battery_overcurrent, i_battery_undervoltage,
		i_input_undervoltage, i_input_overvoltage, i_input_dpm_active,
		i_chip_disable_input, i_timer_fault, i_reset_condition,
		i_sda_in, i_scl};

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s1_q   <= SYNC_RST;
			s2_q   <= SYNC_RST;
			s3_q   <= SYNC_RST;
			pin_q  <= SYNC_RST;
			prev_q <= SYNC_RST;
		end else begin
			s1_q   <= pins;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			// take a bit only once stages two and three agree
			pin_q  <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
			prev_q <= pin_q;
		end
	end

	assign rst_rise = pin_q[PIN_RSTC] & ~prev_q[PIN_RSTC];
	assign uv_rise  = pin_q[PIN_UV] & ~prev_q[PIN_UV];
	assign ocp_rise = pin_q[PIN_OCP] & ~prev_q[PIN_OCP];
	assign cd_edge  = pin_q[PIN_CD] ^ prev_q[PIN_CD];

	// -------------------------------------------------------------
	// serial port
	// -------------------------------------------------------------
	serial_reg_port u_port (
		.i_core_clk  (i_core_clk),
		.i_nrst      (i_nrst),
		.i_scl       (pin_q[PIN_SCL]),
		.i_sda       (pin_q[PIN_SDA]),
		.o_sda_oe_n  (port_oe_n),
		.i_rd_data   (rd_data),
		.o_ptr       (ptr),
		.o_wr        (wr),
		.o_wr_addr   (wr_addr),
		.o_wr_data   (wr_data),
		.o_rd_done   (rd_done),
		.o_done_addr (done_addr)
	);

	assign o_sda_oe_n = port_oe_n;

	// open drain: data is always low, only the enable moves
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_sda_out <= 1'b0;
		end else begin
			o_sda_out <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// writable fields
	// -------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_ship_mode_request <= SHIP_RST;
			o_fault_masks       <= FAULT_MASK_RST;
			o_ts_enable         <= TS_EN_RST;
			o_ts_event_ctrl     <= TS_LOW_RST;
		end else if (wr) begin
			case (wr_addr)
			ADDR_STATUS: begin
				o_ship_mode_request <= wr_data[ST_SHIP];
			end
			ADDR_FAULT: begin
				o_fault_masks <= wr_data[3:0];
			end
			ADDR_TS: begin
				o_ts_enable     <= wr_data[TS_EN];
				o_ts_event_ctrl <= wr_data[3:0];
			end
			default: begin
			end
			endcase
		end
	end

	// -------------------------------------------------------------
	// fault and event flags
	// -------------------------------------------------------------
	// cleared only once the byte holding them has gone out
	assign clr_status = rd_done && done_addr == ADDR_STATUS;
	assign clr_fault  = rd_done && done_addr == ADDR_FAULT;

	// set beats clear in the same cycle
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rstf_q <= 1'b0;
			tmr_q  <= 1'b0;
		end else begin
			rstf_q <= rst_rise | (rstf_q & ~clr_status);
			tmr_q  <= pin_q[PIN_TMR] | (tmr_q & ~cd_edge);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ov_q  <= 1'b0;
			uv_q  <= 1'b0;
			buv_q <= 1'b0;
			ocp_q <= 1'b0;
		end else begin
			ov_q  <= (pin_q[PIN_OV] & ~o_fault_masks[FM_OV]) |
				(ov_q & ~clr_fault);
			uv_q  <= (uv_rise & ~o_fault_masks[FM_UV]) |
				(uv_q & ~clr_fault);
			buv_q <= (pin_q[PIN_BUV] & ~o_fault_masks[FM_BUV]) |
				(buv_q & ~clr_fault);
			ocp_q <= (ocp_rise & ~o_fault_masks[FM_OCP]) |
				(ocp_q & ~clr_fault);
		end
	end

	// -------------------------------------------------------------
	// read mux
	// -------------------------------------------------------------
	always_comb begin
		case (ptr)
		ADDR_STATUS: begin
			rd_data = {pin_q[PIN_CHG1:PIN_CHG0], 1'b0, rstf_q, tmr_q,
				pin_q[PIN_DPM], pin_q[PIN_CD], pin_q[PIN_SYS]};
		end
		ADDR_FAULT: begin
			rd_data = {ov_q, uv_q, buv_q, ocp_q, o_fault_masks};
		end
		ADDR_TS: begin
			rd_data = {o_ts_enable, pin_q[PIN_TS1:PIN_TS0], 1'b0,
				o_ts_event_ctrl};
		end
		default: begin
			rd_data = UNMAPPED_VAL;
		end
		endcase
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_nrst);

	property p_charge_state;
		(ptr == ADDR_STATUS) |->
			rd_data[7:6] == pin_q[PIN_CHG1:PIN_CHG0];
	endproperty
	a_charge_state: assert property (p_charge_state)
		else $error("charge state bits differ from input");

	property p_ship_write;
		(wr && wr_addr == ADDR_STATUS) |=>
			o_ship_mode_request == $past(wr_data[ST_SHIP]);
	endproperty
	a_ship_write: assert property (p_ship_write)
		else $error("ship request not taken from write");

	property p_reset_flag_clear;
		(clr_status && !rst_rise) |=> !rstf_q ##1 (rstf_q == $past(rst_rise));
	endproperty
	a_reset_flag_clear: assert property (p_reset_flag_clear)
		else $error("reset flag not cleared by read");

	property p_timer_hold;
		(tmr_q && !cd_edge) |=> tmr_q;
	endproperty
	a_timer_hold: assert property (p_timer_hold)
		else $error("timer flag dropped without disable toggle");

	property p_dpm_mirror;
		(ptr == ADDR_STATUS) |-> rd_data[2] == pin_q[PIN_DPM];
	endproperty
	a_dpm_mirror: assert property (p_dpm_mirror)
		else $error("dpm status bit wrong");

	property p_ov_hold;
		(pin_q[PIN_OV] && !o_fault_masks[FM_OV]) |=> ov_q;
	endproperty
	a_ov_hold: assert property (p_ov_hold)
		else $error("overvoltage flag lost while present");

	property p_uv_once;
		(clr_fault && !uv_rise) |=> !uv_q;
	endproperty
	a_uv_once: assert property (p_uv_once)
		else $error("undervoltage flag survived read");

	property p_buv_hold;
		(pin_q[PIN_BUV] && !o_fault_masks[FM_BUV]) |=> buv_q;
	endproperty
	a_buv_hold: assert property (p_buv_hold)
		else $error("battery undervoltage flag lost");

	property p_ocp_clear;
		(clr_fault && !ocp_rise) |=> !ocp_q;
	endproperty
	a_ocp_clear: assert property (p_ocp_clear)
		else $error("overcurrent flag survived read");

	property p_mask_write;
		(wr && wr_addr == ADDR_FAULT) |=>
			o_fault_masks == $past(wr_data[3:0]);
	endproperty
	a_mask_write: assert property (p_mask_write)
		else $error("fault masks not written");

	property p_ship_reads_zero;
		(ptr == ADDR_STATUS) |-> !rd_data[ST_SHIP];
	endproperty
	a_ship_reads_zero: assert property (p_ship_reads_zero)
		else $error("write-only bit reads back");

	property p_ts_write;
		(wr && wr_addr == ADDR_TS) |=>
			{o_ts_enable, o_ts_event_ctrl} ==
			$past({wr_data[TS_EN], wr_data[3:0]});
	endproperty
	a_ts_write: assert property (p_ts_write)
		else $error("ts control not written");

	property p_unmapped;
		(ptr > ADDR_TS) |-> rd_data == UNMAPPED_VAL;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not all ones");

endmodule

`default_nettype wire

// >>> logic/charger_regs_pkg.sv
/*
 * Constants of the charger status, fault and temperature-sense register
 * bank: serial slave address, register offsets, field positions, reset
 * values and the layout of the synchronised input vector.
 * Assumes a single core clock; no timing counts are needed.
 */
`default_nettype none

package charger_regs_pkg;

	// -------------------------------------------------------------
	// serial port and map
	// -------------------------------------------------------------
	localparam logic [6:0] SLAVE_ADDR   = 7'h6A;
	localparam logic [7:0] ADDR_STATUS  = 8'h00;
	localparam logic [7:0] ADDR_FAULT   = 8'h01;
	localparam logic [7:0] ADDR_TS      = 8'h02;
	localparam logic [7:0] UNMAPPED_VAL = 8'hFF;

	// -------------------------------------------------------------
	// charge-state codes
	// -------------------------------------------------------------
	typedef enum logic [1:0] {
		CHG_READY       = 2'h0,
		CHG_IN_PROGRESS = 2'h1,
		CHG_DONE        = 2'h2,
		CHG_FAULT       = 2'h3
	} charge_state_e;

	// -------------------------------------------------------------
	// field positions
	// -------------------------------------------------------------
	localparam int ST_SHIP  = 5;
	localparam int ST_RSTF  = 4;
	localparam int FM_OV    = 3;
	localparam int FM_UV    = 2;
	localparam int FM_BUV   = 1;
	localparam int FM_OCP   = 0;
	localparam int TS_EN    = 7;

	// -------------------------------------------------------------
	// reset values
	// -------------------------------------------------------------
	localparam logic [3:0] FAULT_MASK_RST = 4'h0;
	localparam logic       TS_EN_RST      = 1'b1;
	localparam logic [3:0] TS_LOW_RST     = 4'h8;
	localparam logic       SHIP_RST       = 1'b0;

	// -------------------------------------------------------------
	// synchronised input vector
	// -------------------------------------------------------------
	localparam int PIN_SCL  = 0;
	localparam int PIN_SDA  = 1;
	localparam int PIN_RSTC = 2;
	localparam int PIN_TMR  = 3;
	localparam int PIN_CD   = 4;
	localparam int PIN_DPM  = 5;
	localparam int PIN_OV   = 6;
	localparam int PIN_UV   = 7;
	localparam int PIN_BUV  = 8;
	localparam int PIN_OCP  = 9;
	localparam int PIN_SYS  = 10;
	localparam int PIN_CHG0 = 11;
	localparam int PIN_CHG1 = 12;
	localparam int PIN_TS0  = 13;
	localparam int PIN_TS1  = 14;
	localparam int NPINS    = 15;
	// idle bus high, system switch reported on
	localparam logic [14:0] SYNC_RST = 15'h0403;

endpackage

`default_nettype wire

// >>> logic/serial_reg_port.sv
/*
 * Byte engine of the serial slave port: start/stop detection, address
 * match, register pointer with auto-increment, write strobes and a
 * byte-sent strobe for read-to-clear logic.
 * Assumes scl and sda already synchronised and filtered on i_core_clk,
 * and a bus slow enough to give several core cycles per bus phase.
 */
`timescale 1ns/1ns
`default_nettype none

module serial_reg_port (
	// clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_nrst,
	// filtered bus lines
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda_oe_n,
	// register side
	input  wire logic [7:0] i_rd_data,
	output logic      [7:0] o_ptr,
	output logic            o_wr,
	output logic      [7:0] o_wr_addr,
	output logic      [7:0] o_wr_data,
	output logic            o_rd_done,
	output logic      [7:0] o_done_addr
);
	import charger_regs_pkg::*;

	typedef enum {S_IDLE, S_ADDR, S_ADDR_ACK, S_RX, S_RX_ACK,
		S_TX, S_TX_ACK, S_WAIT} port_state_e;

	port_state_e state_q;
	logic        scl_q;
	logic        sda_q;
	logic [7:0]  sh_q;
	logic [3:0]  cnt_q;
	logic        rw_q;
	logic        first_q;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_c;
	logic        stop_c;

	assign scl_rise = i_scl & ~scl_q;
	assign scl_fall = ~i_scl & scl_q;
	assign start_c  = scl_q & i_scl & sda_q & ~i_sda;
	assign stop_c   = scl_q & i_scl & ~sda_q & i_sda;

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= i_scl;
			sda_q <= i_sda;
		end
	end

	// -------------------------------------------------------------
	// byte sequencer
	// -------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q     <= S_IDLE;
			sh_q        <= 8'h00;
			cnt_q       <= 4'h0;
			rw_q        <= 1'b0;
			first_q     <= 1'b0;
			o_sda_oe_n  <= 1'b1;
			o_ptr       <= 8'h00;
			o_wr        <= 1'b0;
			o_wr_addr   <= 8'h00;
			o_wr_data   <= 8'h00;
			o_rd_done   <= 1'b0;
			o_done_addr <= 8'h00;
		end else begin
			o_wr      <= 1'b0;
			o_rd_done <= 1'b0;
			if (start_c) begin
				state_q    <= S_ADDR;
				cnt_q      <= 4'h0;
				first_q    <= 1'b1;
				o_sda_oe_n <= 1'b1;
			end else if (stop_c) begin
				state_q    <= S_IDLE;
				o_sda_oe_n <= 1'b1;
			end else begin
				case (state_q)
				S_ADDR, S_RX: begin
					if (scl_rise && cnt_q != 4'h8) begin
						sh_q  <= {sh_q[6:0], i_sda};
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						if (state_q == S_ADDR) begin
							if (sh_q[7:1] == SLAVE_ADDR) begin
								o_sda_oe_n <= 1'b0;
								rw_q       <= sh_q[0];
								state_q    <= S_ADDR_ACK;
							end else begin
								state_q <= S_WAIT;
							end
						end else begin
							o_sda_oe_n <= 1'b0;
							state_q    <= S_RX_ACK;
							if (first_q) begin
								o_ptr   <= sh_q;
								first_q <= 1'b0;
							end else begin
								o_wr      <= 1'b1;
								o_wr_addr <= o_ptr;
								o_wr_data <= sh_q;
								o_ptr     <= o_ptr + 8'h01;
							end
						end
					end
				end
				S_ADDR_ACK, S_TX_ACK: begin
					if (scl_rise && state_q == S_TX_ACK && i_sda) begin
						state_q <= S_WAIT;
					end else if (scl_fall) begin
						if (rw_q) begin
							sh_q       <= i_rd_data;
							o_sda_oe_n <= i_rd_data[7];
							cnt_q      <= 4'h1;
							state_q    <= S_TX;
						end else begin
							o_sda_oe_n <= 1'b1;
							cnt_q      <= 4'h0;
							state_q    <= S_RX;
						end
					end
				end
				S_RX_ACK: begin
					if (scl_fall) begin
						o_sda_oe_n <= 1'b1;
						cnt_q      <= 4'h0;
						state_q    <= S_RX;
					end
				end
				S_TX: begin
					if (scl_fall) begin
						if (cnt_q == 4'h8) begin
							// byte fully shifted out
							o_sda_oe_n  <= 1'b1;
							o_rd_done   <= 1'b1;
							o_done_addr <= o_ptr;
							o_ptr       <= o_ptr + 8'h01;
							state_q     <= S_TX_ACK;
						end else begin
							sh_q       <= {sh_q[6:0], 1'b0};
							o_sda_oe_n <= sh_q[6];
							cnt_q      <= cnt_q + 4'h1;
						end
					end
				end
				default: begin
					o_sda_oe_n <= 1'b1;
				end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// >>> test/i2c_host_model.sv
/*
 * Host master model of the two-wire register port.
 * Assumes a pull-up on the data line and one core clock for timing.
 */
`timescale 1ns/1ns
`default_nettype none

module i2c_host_model
	import charger_regs_pkg::*;
(
	// timing clock
	input  wire logic i_clk,
	// device side of the data pin
	input  wire logic i_sda_oe_n,
	input  wire logic i_sda_out,
	// bus lines
	output logic      o_scl,
	output logic      o_sda
);
	localparam int H = 12;
	logic m_sda;

	// ---------------------------------------------------------
	// wired line: pull-up unless a party pulls low
	// ---------------------------------------------------------
	assign o_sda = m_sda & (i_sda_oe_n | i_sda_out);

	initial begin
		o_scl = 1'b1;
		m_sda = 1'b1;
	end

	// ---------------------------------------------------------
	// bus phases
	// ---------------------------------------------------------
	task automatic hw();
		repeat (H) @(posedge i_clk);
	endtask

	// start or repeated start
	task automatic st();
		m_sda <= 1'b1;
		hw();
		o_scl <= 1'b1;
		hw();
		m_sda <= 1'b0;
		hw();
		o_scl <= 1'b0;
		hw();
	endtask

	task automatic sp();
		m_sda <= 1'b0;
		hw();
		o_scl <= 1'b1;
		hw();
		m_sda <= 1'b1;
		hw();
	endtask

	// one bit, line sampled at end of clock high
	task automatic bt(input logic b, output logic r);
		m_sda <= b;
		hw();
		o_scl <= 1'b1;
		hw();
		r = o_sda;
		o_scl <= 1'b0;
		hw();
	endtask

	// eight bits msb first, then the ninth bit
	task automatic by(input logic [7:0] d, input logic a,
		output logic [7:0] q, output logic r);
		for (int i = 7; i >= 0; i--) begin
			bt(d[i], q[i]);
		end
		bt(a, r);
	endtask

	// ---------------------------------------------------------
	// register transfers
	// ---------------------------------------------------------
	task automatic wr(input logic [6:0] sa, input logic [7:0] p,
		input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic       r;
		st();
		by({sa, 1'b0}, 1'b1, q, r);
		ok = ~r;
		if (ok) begin
			by(p, 1'b1, q, r);
			by(d, 1'b1, q, r);
		end
		sp();
	endtask

	task automatic rd(input logic [7:0] p, output logic [7:0] q,
		output logic ok);
		logic r;
		logic a;
		st();
		by({SLAVE_ADDR, 1'b0}, 1'b1, q, r);
		by(p, 1'b1, q, a);
		st();
		by({SLAVE_ADDR, 1'b1}, 1'b1, q, r);
		ok = ~(r | a);
		by(8'hFF, 1'b1, q, r);
		sp();
	endtask
endmodule

`default_nettype wire

// >>> test/charger_status_fault_regs_tb.sv
/*
 * Self-checking bench of the charger register bank.
 * Assumes the host model file and the register package are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none

module charger_status_fault_regs_tb;
	import charger_regs_pkg::*;
	logic       clk = 1'b0;
	logic       nrst;
	logic       scl, sda, sda_out, sda_oe_n, ok;
	logic [1:0] chg, tsm;
	logic       rstc, tmr, cd, dpm, ov, uv, buv, ocp, sys;
	logic       ship, ts_en;
	logic [3:0] masks, ts_ctl;
	logic [7:0] q, v;
	logic [31:0] seed = 32'hCE3134BF;
	int         errors = 0;
	int         check_count = 0;

	always #50 clk = ~clk;

	charger_status_fault_regs dut (.i_core_clk(clk), .i_nrst(nrst),
		.i_scl(scl), .i_sda_in(sda), .o_sda_out(sda_out),
		.o_sda_oe_n(sda_oe_n), .i_charge_state(chg),
		.i_reset_condition(rstc), .i_timer_fault(tmr),
		.i_chip_disable_input(cd), .i_input_dpm_active(dpm),
		.i_input_overvoltage(ov), .i_input_undervoltage(uv),
		.i_battery_undervoltage(buv), .i_battery_overcurrent(ocp),
		.i_sys_switch_en(sys), .i_ts_fault_mode(tsm),
		.o_ship_mode_request(ship), .o_fault_masks(masks),
		.o_ts_enable(ts_en), .o_ts_event_ctrl(ts_ctl));

	i2c_host_model host (.i_clk(clk), .i_sda_oe_n(sda_oe_n),
		.i_sda_out(sda_out), .o_scl(scl), .o_sda(sda));

	// ---------------------------------------------------------
	// helpers
	// ---------------------------------------------------------
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	function automatic logic [7:0] st_e(input logic rf, input logic tf);
		return {chg, 1'b0, rf, tf, dpm, 1'b0, sys};
	endfunction

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("ERROR t=%0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic rdc(input logic [7:0] p, input logic [7:0] e,
		input logic [7:0] m);
		host.rd(p, q, ok);
		chk(q & m, e & m);
		chk({7'h00, ok}, 8'h01);
	endtask

	task automatic wrc(input logic [7:0] p, input logic [7:0] d);
		host.wr(SLAVE_ADDR, p, d, ok);
		chk({7'h00, ok}, 8'h01);
	endtask

	task automatic sl();
		repeat (10) @(posedge clk);
	endtask

	task automatic fin(input string n);
		$display("test %s finished", n);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (80000) @(posedge clk);
		errors++;
		$display("ERROR t=%0t watchdog expired", $time);
		end_of_test();
	end

	// ---------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------
	initial begin
		nrst = 1'b0;
		{chg, rstc, tmr, cd, ov, uv, buv, ocp} = '0;
		v = rnd();
		{dpm, sys, tsm} = v[3:0];
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		sl();
		chk({3'h0, ship, masks}, 8'h00);
		chk({3'h0, ts_en, ts_ctl}, 8'h18);
		rdc(ADDR_STATUS, st_e(0, 0), 8'hFD);
		rdc(ADDR_FAULT, 8'h00, 8'hFF);
		rdc(ADDR_TS, {1'b1, tsm, 5'h08}, 8'hFF);
		fin("reset");
		for (int i = 0; i < 4; i++) begin
			v = rnd();
			chg <= i[1:0];
			dpm <= v[0];
			sl();
			rdc(ADDR_STATUS, st_e(0, 0), 8'hFD);
		end
		// fault state with no fault flag set: fault flag bits 7:4 read zero
		rdc(ADDR_FAULT, 8'h00, 8'hF0);
		fin("charge state");
		wrc(ADDR_STATUS, 8'h20);
		chk({7'h00, ship}, 8'h01);
		rdc(ADDR_STATUS, 8'h00, 8'h20);
		wrc(ADDR_STATUS, 8'h00);
		chk({7'h00, ship}, 8'h00);
		v = rnd();
		wrc(ADDR_FAULT, v);
		chk({4'h0, masks}, {4'h0, v[3:0]});
		rdc(ADDR_FAULT, {4'h0, v[3:0]}, 8'hFF);
		wrc(ADDR_FAULT, 8'h00);
		v = rnd();
		wrc(ADDR_TS, v);
		chk({3'h0, ts_en, ts_ctl}, {3'h0, v[7], v[3:0]});
		rdc(ADDR_TS, {v[7], tsm, 1'b0, v[3:0]}, 8'hFF);
		fin("writes");
		v = rnd();
		rdc(8'h03, UNMAPPED_VAL, 8'hFF);
		rdc(v | 8'h04, UNMAPPED_VAL, 8'hFF);
		host.wr(SLAVE_ADDR ^ 7'h01, ADDR_FAULT, 8'h0F, ok);
		chk({7'h00, ok}, 8'h00);
		chk({4'h0, masks}, 8'h00);
		fin("map");
		rstc <= 1'b1;
		sl();
		rstc <= 1'b0;
		tmr <= 1'b1;
		sl();
		tmr <= 1'b0;
		sl();
		rdc(ADDR_STATUS, st_e(1, 1), 8'hFD);
		rdc(ADDR_STATUS, st_e(0, 1), 8'hFD);
		cd <= 1'b1;
		sl();
		rdc(ADDR_STATUS, st_e(0, 0), 8'hFD);
		fin("status flags");
		{ov, uv, buv, ocp} <= 4'hF;
		sl();
		{uv, ocp} <= 2'b00;
		sl();
		rdc(ADDR_FAULT, 8'hF0, 8'hFF);
		rdc(ADDR_FAULT, 8'hA0, 8'hFF);
		{ov, buv} <= 2'b00;
		sl();
		rdc(ADDR_FAULT, 8'hA0, 8'hFF);
		rdc(ADDR_FAULT, 8'h00, 8'hFF);
		wrc(ADDR_FAULT, 8'h0F);
		{ov, uv, buv, ocp} <= 4'hF;
		sl();
		{ov, uv, buv, ocp} <= 4'h0;
		sl();
		rdc(ADDR_FAULT, 8'h0F, 8'hFF);
		fin("fault flags");
		end_of_test();
	end
endmodule

`default_nettype wire
